/* File: kvm_select_regs.vh */
/*
  constants for the channel select and authentication reset block:
  selection mechanism codes, timing and reset values.
  assumes inclusion by bare name from the design file.
*/
`ifndef KVM_SELECT_REGS_VH
`define KVM_SELECT_REGS_VH

// -----------------------------------------------------------------
// selection mechanisms
// -----------------------------------------------------------------
`define MECH_BUTTONS      2'h0
`define MECH_REMOTE      2'h1
`define MECH_SERIAL      2'h2

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLOCK_HZ         100000000
`define AUTH_OFF_MS      1000
`define AUTH_OFF_CYCLES  ((`CLOCK_HZ / 1000) * `AUTH_OFF_MS)

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RST_HOST         2'h0
`define RST_MECH         2'h0

`endif

/* File: kvm_channel_select.v */
/*
  channel selection, peripheral routing and authentication device power
  control of a secure multi-host keyboard/video/mouse switch.
  assumes all inputs except key_combo_req, local role/filter/mechanism requests and auth_emulated come from
  pins and are synchronised here; host requests are one-hot per mechanism.
*/
// What this block does
// - host change powers a non-emulated auth device off 1 s
// - auth device routed on own path
// - filter list writes only from administrator
// - track user and administrator roles
// - keyboard combination switch requests are ignored
// - only one selection mechanism active
// - indicator shows selected host from power-up
// - keyboard and mouse switch together; identification is reported, routing does not wait for it
`timescale 1ns/1ps
`default_nettype none
`include "kvm_select_regs.vh"

module kvm_channel_select #(
  parameter integer HOSTS       = 4,
  parameter integer HW          = 2,
  parameter integer OFF_CYCLES  = `AUTH_OFF_CYCLES,
  parameter integer FILTER_ENTRIES = 8
) (
  input  wire                 clock,
  input  wire                 nrst,
  input  wire [HOSTS-1:0]     button_req,
  input  wire [HOSTS-1:0]     remote_req,
  input  wire [HOSTS-1:0]     serial_req,
  input  wire [HOSTS-1:0]     key_combo_req,
  input  wire [1:0]           mech_sel,
  input  wire                 mech_sel_we,
  input  wire                 kbd_identified,
  input  wire                 mouse_identified,
  input  wire                 auth_emulated,
  input  wire                 admin_login,
  input  wire                 admin_logout,
  input  wire                 filter_we,
  input  wire [2:0]           filter_idx,
  input  wire                 filter_allow,
  input  wire [15:0]          filter_id,
  output reg  [HW-1:0]        kbd_route_ff,
  output reg  [HW-1:0]        mouse_route_ff,
  output reg  [HW-1:0]        auth_route_ff,
  output reg                  kbd_mouse_en_ff,
  output reg  [HOSTS-1:0]     host_led_ff,
  output reg                  auth_power_ff,
  output reg                  admin_active_ff,
  output reg                  filter_refused_ff,
  output reg  [16:0]          filter_entry_ff
);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  localparam integer SW = 3*HOSTS + 2;
  wire [SW-1:0] raw_in = {button_req, remote_req, serial_req, kbd_identified, mouse_identified};
  reg  [SW-1:0] meta_ff;
  reg  [SW-1:0] sync_ff;
  reg  [SW-1:0] prev_ff;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= {SW{1'b0}};
      sync_ff <= {SW{1'b0}};
      prev_ff <= {SW{1'b0}};
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
  // edges are taken from the second stage only; meta_ff feeds sync_ff
  // and nothing else, so a metastable sample never reaches the decode
  wire [SW-1:0]    rise    = sync_ff & ~prev_ff;
  wire [HOSTS-1:0] btn_r   = rise[SW-1 -: HOSTS];
  wire [HOSTS-1:0] rem_r   = rise[SW-1-HOSTS -: HOSTS];
  wire [HOSTS-1:0] ser_r   = rise[SW-1-2*HOSTS -: HOSTS];
  wire             kbd_ok  = sync_ff[1];
  wire             mouse_ok = sync_ff[0];

  // -----------------------------------------------------------------
  // mechanism choice and role
  // -----------------------------------------------------------------
  reg [1:0] mech_ff;
  wire      mech_code_ok = (mech_sel <= `MECH_SERIAL);

  // changing the mechanism is itself an administrative act; an unknown
  // code is dropped so the enabled mechanism is never left undefined
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mech_ff <= `RST_MECH;
    end else if (mech_sel_we && admin_active_ff && mech_code_ok) begin
      mech_ff <= mech_sel;
    end
  end

  // logout wins over login so a stuck login line cannot keep the role
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      admin_active_ff <= 1'b0;
    end else if (admin_logout) begin
      admin_active_ff <= 1'b0;
    end else if (admin_login) begin
      admin_active_ff <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // request decode
  // -----------------------------------------------------------------
  // only the enabled mechanism is looked at; key combinations never are
  reg [HOSTS-1:0] req_vec;
  always @* begin
    case (mech_ff)
      `MECH_BUTTONS: req_vec = btn_r;
      `MECH_REMOTE:  req_vec = rem_r;
      `MECH_SERIAL:  req_vec = ser_r;
      default:       req_vec = {HOSTS{1'b0}};
    endcase
  end
  // key_combo_req is deliberately left out of the request path
  wire unused_combo = |key_combo_req;

  // -----------------------------------------------------------------
  // host choice
  // -----------------------------------------------------------------
  // lowest index wins when two buttons rise together
  reg [HW-1:0] req_host;
  reg          req_valid;
  integer      i;
  always @* begin
    req_host  = {HW{1'b0}};
    req_valid = 1'b0;
    for (i = HOSTS-1; i >= 0; i = i - 1) begin
      if (req_vec[i]) begin
        req_host  = i[HW-1:0];
        req_valid = 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // routing, indicator and auth power
  // -----------------------------------------------------------------
  // a zero off time would leave the port unpowered for good, so the
  // counter always loads at least one cycle
  localparam integer  CW       = 32;
  localparam integer  OFF_LOAD = (OFF_CYCLES < 1) ? 1 : OFF_CYCLES;
  localparam [CW-1:0] ONE      = {{(CW-1){1'b0}}, 1'b1};
  localparam [CW-1:0] LOAD     = OFF_LOAD;
  reg [CW-1:0] off_cnt_ff;
  wire         change   = req_valid && (req_host != kbd_route_ff);
  wire         cut_pwr  = change && !auth_emulated;
  wire         off_last = (off_cnt_ff == ONE);

  // one register set moves every route and the indicator, so they can
  // never be seen pointing at different hosts
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      kbd_route_ff   <= `RST_HOST;
      mouse_route_ff <= `RST_HOST;
      auth_route_ff  <= `RST_HOST;
      host_led_ff    <= {{(HOSTS-1){1'b0}}, 1'b1};
    end else if (change) begin
      kbd_route_ff   <= req_host;
      mouse_route_ff <= req_host;
      auth_route_ff  <= req_host;
      host_led_ff    <= {{(HOSTS-1){1'b0}}, 1'b1} << req_host;
    end
  end

  // reported only; routing does not wait for it
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      kbd_mouse_en_ff <= 1'b0;
    end else begin
      kbd_mouse_en_ff <= kbd_ok && mouse_ok;
    end
  end

  // a new change restarts the full off interval; an emulated auth
  // function keeps its power through a switch
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      auth_power_ff <= 1'b1;
      off_cnt_ff    <= {CW{1'b0}};
    end else if (cut_pwr) begin
      auth_power_ff <= 1'b0;
      off_cnt_ff    <= LOAD;
    end else if (off_cnt_ff != {CW{1'b0}}) begin
      off_cnt_ff <= off_cnt_ff - ONE;
      if (off_last) begin
        auth_power_ff <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // auth device filter list
  // -----------------------------------------------------------------
  // entries survive a logout; only the write path is gated by role.
  // the read port is registered so the entry output is a flop as well
  reg [16:0] filter_mem [0:FILTER_ENTRIES-1];
  integer    k;
  wire       filter_ok  = filter_we && admin_active_ff;
  wire       filter_bad = filter_we && !admin_active_ff;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      filter_refused_ff <= 1'b0;
      filter_entry_ff   <= 17'h0_0000;
      for (k = 0; k < FILTER_ENTRIES; k = k + 1) begin
        filter_mem[k] <= 17'h0_0000;
      end
    end else begin
      filter_refused_ff <= filter_bad;
      if (filter_ok) begin
        filter_mem[filter_idx] <= {filter_allow, filter_id};
      end
      filter_entry_ff <= filter_mem[filter_idx];
    end
  end

endmodule // kvm_channel_select
`default_nettype wire

/* File: kvm_select_sva.sv */
/* port checker for kvm_channel_select.
   assumes the bind hands on OFF_CYCLES and the four-host build. */
`timescale 1ns/1ps
`default_nettype none
module kvm_select_sva #(parameter int OFF_CYCLES = 20) (
  input wire logic       clock, nrst, auth_emulated, filter_we, admin_logout,
  input wire logic [3:0] button_req, remote_req, serial_req, host_led_ff,
  input wire logic [1:0] kbd_route_ff, mouse_route_ff, auth_route_ff,
  input wire logic       auth_power_ff, admin_active_ff, filter_refused_ff
);
  wire any_req;
  assign any_req = |{button_req, remote_req, serial_req};
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_routes_tied: assert property (kbd_route_ff == mouse_route_ff && kbd_route_ff == auth_route_ff)
    else $error("routes differ");
  a_led_route: assert property (host_led_ff == 4'h1 << kbd_route_ff)
    else $error("indicator disagrees with route");
  // a pin must have been up three edges before any switch
  a_req_cause: assert property ($changed(kbd_route_ff) |-> $past(any_req, 3))
    else $error("switch without request");
  a_power_drop: assert property ($changed(kbd_route_ff) && !auth_emulated |-> !auth_power_ff)
    else $error("no power cut on switch");
  a_power_emul: assert property ($changed(kbd_route_ff) && auth_emulated && $past(auth_power_ff) |->
    auth_power_ff) else $error("power cut while emulated");
  a_power_low: assert property ($fell(auth_power_ff) |-> !auth_power_ff [*8])
    else $error("power back too soon");
  a_power_back: assert property ($fell(auth_power_ff) |-> ##OFF_CYCLES auth_power_ff)
    else $error("power not back on time");
  a_filter_refuse: assert property (filter_we && !admin_active_ff |=> filter_refused_ff)
    else $error("user write not refused");
  a_filter_admin: assert property (filter_we && admin_active_ff |=> !filter_refused_ff)
    else $error("admin write refused");
  a_logout_wins: assert property (admin_logout |=> !admin_active_ff)
    else $error("admin role kept");
endmodule // kvm_select_sva
bind kvm_channel_select kvm_select_sva #(.OFF_CYCLES(OFF_CYCLES)) i_sva (.*);
`default_nettype wire

/* File: kvm_periph_model.sv */
/* keyboard and mouse on the console ports.
   assumes present is held while the devices stay plugged. */
`timescale 1ns/1ps
`default_nettype none
module kvm_periph_model (
  input  wire logic clock,
  input  wire logic present,
  output var  logic kbd_identified,
  output var  logic mouse_identified
);
  logic [2:0] age = 3'h0;
  initial {kbd_identified, mouse_identified} = 2'h0;
  // enumeration takes a few cycles, mouse answers one later
  always @(negedge clock) begin
    age <= present ? age + {2'h0, age != 3'h7} : 3'h0;
    kbd_identified <= age >= 3'h4;
    mouse_identified <= age >= 3'h5;
  end
endmodule // kvm_periph_model
`default_nettype wire

/* File: tb.sv */
/* self-checking bench for kvm_channel_select.
   assumes OFF_CYCLES of 20 and a 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clock = 0, nrst = 0, mech_sel_we = 0, auth_emulated = 0, admin_login = 0, admin_logout = 0;
  logic       filter_we = 0, filter_allow = 0, present = 0;
  logic [3:0] button_req = 0, remote_req = 0, serial_req = 0, key_combo_req = 0;
  logic [1:0] mech_sel = 0, kbd_route_ff, mouse_route_ff, auth_route_ff;
  logic [2:0] filter_idx = 0;
  logic [15:0] filter_id = 0;
  logic [3:0] host_led_ff;
  logic [16:0] filter_entry_ff;
  logic       kbd_mouse_en_ff, auth_power_ff, admin_active_ff, filter_refused_ff, kbd_identified, mouse_identified;
  integer     seed = 44123, err_count = 0, total_checks = 0, i, cur = 0;
  always #5 clock = ~clock;
  kvm_channel_select #(.OFF_CYCLES(20)) i_dut (.*);
  kvm_periph_model i_periph (.clock, .present, .kbd_identified, .mouse_identified);
  task automatic chk(input string what, input logic [16:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n); repeat (n) @(negedge clock); endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [3:0] led_of(input int h);
    return 4'h1 << h;
  endfunction
  // m 3 is the keyboard shortcut; pin up two cycles, switch lands on the third edge
  task automatic select(input int m, k, mech);
    logic sw;
    sw = (m == mech) && (k != cur);
    case (m) 0: button_req[k] = 1; 1: remote_req[k] = 1; 2: serial_req[k] = 1; default: key_combo_req[k] = 1; endcase
    cyc(2);
    {button_req, remote_req, serial_req, key_combo_req} = 0;
    cyc(2);
    if (sw) cur = k;
    chk("route", cur, kbd_route_ff);
    chk("mouse route", cur, mouse_route_ff);
    chk("auth route", cur, auth_route_ff);
    chk("led", led_of(cur), host_led_ff);
    chk("power", !(sw && !auth_emulated), auth_power_ff);
    cyc(18);
    chk("power held", !(sw && !auth_emulated), auth_power_ff);
    cyc(2);
    chk("power back", 1, auth_power_ff);
  endtask
  initial begin
    cyc(16);
    nrst = 1;
    chk("led reset", 4'h1, host_led_ff);
    present = 1;
    for (i = 0; i < 20 && kbd_mouse_en_ff !== 1'b1; i++) cyc(1);
    chk("kbd mouse enable", 1, kbd_mouse_en_ff);
    for (i = 0; i < 14; i++) select({$random(seed)} % 4, {$random(seed)} % 4, 0);
    select(3, 3 - cur, 0);
    select(0, cur, 0);
    $display("test select done");
    mech_sel = 1;
    mech_sel_we = 1;
    cyc(1);
    mech_sel_we = 0;
    select(1, (cur + 1) % 4, 0);
    admin_login = 1;
    cyc(1);
    {admin_login, mech_sel_we} = 2'h1;
    cyc(1);
    mech_sel_we = 0;
    select(0, (cur + 1) % 4, 1);
    select(1, (cur + 1) % 4, 1);
    {mech_sel, mech_sel_we} = {2'h3, 1'b1};
    cyc(1);
    mech_sel_we = 0;
    select(1, (cur + 1) % 4, 1);
    {mech_sel, mech_sel_we} = {2'h2, 1'b1};
    cyc(1);
    mech_sel_we = 0;
    select(1, (cur + 1) % 4, 2);
    select(2, (cur + 1) % 4, 2);
    {filter_idx, filter_allow, filter_id, filter_we} = {3'h5, 1'b1, 16'($random(seed)), 1'b1};
    cyc(1);
    filter_we = 0;
    cyc(1);
    chk("entry", {1'b1, filter_id}, filter_entry_ff);
    admin_logout = 1;
    cyc(1);
    admin_logout = 0;
    chk("admin", 0, admin_active_ff);
    {filter_id, filter_we} = {~filter_id, 1'b1};
    cyc(1);
    filter_we = 0;
    chk("refused", 1, filter_refused_ff);
    cyc(1);
    chk("entry kept", {1'b1, ~filter_id}, filter_entry_ff);
    auth_emulated = 1;
    select(2, (cur + 1) % 4, 2);
    $display("test admin done");
    complete_run;
  end
  initial begin
    cyc(5000);
    err_count++;
    complete_run;
  end
endmodule // tb
`default_nettype wire
